// File: common/stimer_pkg.sv
// Purpose: constants for the standard timer with compare and pwm
// Assumes: classic wishbone, 32-bit data, one register per aligned word
// Notes:   offsets are byte addresses
package stimer_pkg;

	// ====================================================================
	// register map
	localparam logic [4:0] STIMER_CTRL0_OFF = 5'h00;
	localparam logic [4:0] STIMER_CTRL1_OFF = 5'h04;
	localparam logic [4:0] STIMER_CNTL_OFF  = 5'h08;
	localparam logic [4:0] STIMER_CNTH_OFF  = 5'h0C;
	localparam logic [4:0] STIMER_CMPAL_OFF = 5'h10;
	localparam logic [4:0] STIMER_CMPAH_OFF = 5'h14;
	localparam logic [4:0] STIMER_CMPP_OFF  = 5'h18;
	localparam logic [4:0] STIMER_FLAG_OFF  = 5'h1C;

	// ====================================================================
	// field positions
	localparam int STIMER_ON_BIT    = 3;
	localparam int STIMER_CCLR_BIT  = 0;
	localparam int STIMER_SWAP_BIT  = 1;
	localparam int STIMER_INV_BIT   = 2;
	localparam int STIMER_OINIT_BIT = 3;
	localparam int STIMER_PFN_LSB   = 4;
	localparam int STIMER_MODE_LSB  = 6;
	localparam int STIMER_FA_BIT    = 0;
	localparam int STIMER_FP_BIT    = 1;

	// ====================================================================
	// reset values and counter maximum
	localparam logic [7:0]  STIMER_BYTE_RST = 8'h00;
	localparam logic [15:0] STIMER_WORD_RST = 16'h0000;
	localparam logic [15:0] STIMER_CNT_MAX  = 16'hFFFF;

	// ====================================================================
	// mode and pin function encodings
	localparam logic [1:0] STIMER_MODE_CMP  = 2'h0;
	localparam logic [1:0] STIMER_MODE_CAP  = 2'h1;
	localparam logic [1:0] STIMER_MODE_PWM  = 2'h2;
	localparam logic [1:0] STIMER_MODE_TMR  = 2'h3;
	localparam logic [1:0] STIMER_PFN_NONE  = 2'h0;
	localparam logic [1:0] STIMER_PFN_LOW   = 2'h1;
	localparam logic [1:0] STIMER_PFN_HIGH  = 2'h2;
	localparam logic [1:0] STIMER_PFN_TOG   = 2'h3;

	typedef enum logic [1:0] {
		STIMER_BUS_IDLE,
		STIMER_BUS_ACK
	} stimer_bus_type;

endpackage

// File: hw/stimer_top.sv
// Purpose: 16-bit up counter with comparators a and p, compare and pwm output
// Assumes: timer clock is the system clock; classic wishbone slave
// Notes:   capture mode only disables parts of the logic
//          the timer clock is the bus clock, so one count per clk_sys_in edge
//          compare a and p are plain bytes with no write latching
//          the invert bit acts on the final pin level in every driven mode
//          the pin is released in timer/counter and capture modes
// How it works
// - swap bit exchanges period and duty roles
// - clear select picks a match or p/overflow
// - overflow clear only when p is zero
// - clear select ignored in pwm/capture
// - counter readable as two read-only bytes
// - compare a is two rw bytes, reset zero
// - p compared against counter top byte only
// - mode 00 is compare match output
// - clear on p sets both match flags
// - clear on a never sets p flag
// - only a match moves the pin
// - counter start loads pin initial level
// - mode 11 like compare, pin not driven
// - pwm raises both flags on matches
// - pwm level, function and invert bits
// - edge pwm period p*256, duty a
// - duty at or above period gives 100 percent
// - start clears counter, stop holds it
// - pin function none/low/high/toggle on a match
`timescale 1ns/1ps
`default_nettype none

module stimer_top
	import stimer_pkg::*;
(
	// clock and reset
	input  wire logic        clk_sys_in,
	input  wire logic        nrst_in,
	// wishbone slave
	input  wire logic        wb_cyc_in,
	input  wire logic        wb_stb_in,
	input  wire logic        wb_we_in,
	input  wire logic [4:0]  wb_adr_in,
	input  wire logic [3:0]  wb_sel_in,
	input  wire logic [31:0] wb_dat_in,
	output logic      [31:0] wb_dat_out,
	output logic             wb_ack_out,
	// timer pin
	output logic             timer_pin_out,
	output logic             timer_pin_oe_n_out
);

	// ====================================================================
	// reset synchroniser
	// only the second flop feeds the design; the first may still be settling
	logic rst_meta_q;
	logic rst_n_q;

	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rst_meta_q <= 1'b0;
			rst_n_q    <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n_q    <= rst_meta_q;
		end
	end

	// ====================================================================
	// state
	logic [7:0]  ctrl0_q;
	logic [7:0]  ctrl1_q;
	logic [15:0] cnt_q;
	logic [15:0] cnt_d;
	logic [15:0] cmp_a_q;
	logic [7:0]  cmp_p_q;
	logic        flag_a_q;
	logic        flag_p_q;
	logic        on_prev_q;
	logic        pin_q;
	logic        pin_d;
	logic        pin_out_q;
	logic        oe_n_q;
	logic        ack_q;
	logic [31:0] rdata_q;

	// ====================================================================
	// field decode
	wire logic       counter_on           = ctrl0_q[STIMER_ON_BIT];
	wire logic [1:0] mode_select          = ctrl1_q[STIMER_MODE_LSB +: 2];
	wire logic [1:0] pin_function         = ctrl1_q[STIMER_PFN_LSB +: 2];
	wire logic       output_initial_level = ctrl1_q[STIMER_OINIT_BIT];
	wire logic       output_invert        = ctrl1_q[STIMER_INV_BIT];
	wire logic       duty_period_swap     = ctrl1_q[STIMER_SWAP_BIT];
	wire logic       clear_source_select  = ctrl1_q[STIMER_CCLR_BIT];

	// ====================================================================
	// mode decode
	// timer/counter mode shares all compare behaviour except the pin
	wire logic on_rise  = counter_on & ~on_prev_q;
	wire logic is_cmp   = (mode_select == STIMER_MODE_CMP) | (mode_select == STIMER_MODE_TMR);
	wire logic is_pwm   = (mode_select == STIMER_MODE_PWM);
	wire logic is_cap   = (mode_select == STIMER_MODE_CAP);

	// ====================================================================
	// comparators
	wire logic match_a  = counter_on & (cnt_q == cmp_a_q);
	// p only sees the top byte; the span ends on the last count before p*256
	wire logic [7:0] p_top_last = cmp_p_q - 8'h01;
	wire logic match_p  = counter_on & (cmp_p_q != 8'h00) & (cnt_q[15:8] == p_top_last)
		& (cnt_q[7:0] == 8'hFF);
	// overflow only counts as the p event while p is zero
	wire logic overflow = counter_on & (cnt_q == STIMER_CNT_MAX) & (cmp_p_q == 8'h00);

	// pwm roles: period source clears the counter, duty source sets the edge
	wire logic pwm_clear_a = duty_period_swap;
	wire logic clear_on_a  = is_pwm ? pwm_clear_a : (is_cmp & clear_source_select);
	wire logic clear_now   = clear_on_a ? match_a : (match_p | overflow);

	// period and duty in counter units; p side becomes p*256 or 65536
	function automatic logic [16:0] p_span(input logic [7:0] p);
		p_span = (p == 8'h00) ? 17'h1_0000 : {1'b0, p, 8'h00};
	endfunction

	wire logic [16:0] pwm_period = duty_period_swap ? {1'b0, cmp_a_q} : p_span(cmp_p_q);
	wire logic [16:0] pwm_duty   = duty_period_swap ? p_span(cmp_p_q) : {1'b0, cmp_a_q};
	wire logic        full_duty  = pwm_duty >= pwm_period;
	wire logic        pwm_active = full_duty | ({1'b0, cnt_q} < pwm_duty);
	wire logic        pwm_level  = pwm_active ? output_initial_level : ~output_initial_level;

	// ====================================================================
	// counter
	// counting only ever clears to zero; software has no direct load
	// capture mode wraps on a p match whatever the clear select says
	always_comb begin
		cnt_d = cnt_q;
		if (on_rise) begin
			cnt_d = STIMER_WORD_RST;
		end else if (counter_on) begin
			if (clear_now & ~is_cap) begin
				cnt_d = STIMER_WORD_RST;
			end else if (is_cap & match_p) begin
				cnt_d = STIMER_WORD_RST;
			end else begin
				cnt_d = cnt_q + 16'h0001;
			end
		end
	end

	// ====================================================================
	// output pin
	// pwm keeps running under a forced level; only the chosen pin source differs
	logic pwm_pin;
	logic cmp_pin;

	always_comb begin
		case (pin_function)
			STIMER_PFN_NONE: pwm_pin = ~output_initial_level;
			STIMER_PFN_LOW:  pwm_pin = output_initial_level;
			STIMER_PFN_HIGH: pwm_pin = pwm_level;
			default:         pwm_pin = pin_q;
		endcase
	end

	// compare mode acts only on an a match; a p match never reaches the pin
	always_comb begin
		case (pin_function)
			STIMER_PFN_LOW:  cmp_pin = 1'b0;
			STIMER_PFN_HIGH: cmp_pin = 1'b1;
			STIMER_PFN_TOG:  cmp_pin = ~pin_q;
			default:         cmp_pin = pin_q;
		endcase
	end

	// start level applies only outside pwm, where the wave owns the pin
	always_comb begin
		pin_d = pin_q;
		if (on_rise & ~is_pwm) begin
			pin_d = output_initial_level;
		end else if (is_pwm) begin
			pin_d = pwm_pin;
		end else if (is_cmp & match_a) begin
			pin_d = cmp_pin;
		end
	end

	// invert acts on the final level; it has nothing to act on once the pin is released
	wire logic oe_n_d    = (mode_select == STIMER_MODE_TMR) | is_cap;
	wire logic pin_out_d = pin_d ^ (output_invert & ~oe_n_d);

	// ====================================================================
	// wishbone decode
	function automatic logic wr_hit(input logic [4:0] adr, input logic [4:0] off);
		wr_hit = (adr == off);
	endfunction

	// only the low byte lane carries register data
	wire logic req     = wb_cyc_in & wb_stb_in & ~ack_q;
	wire logic wr_req  = req & wb_we_in & wb_sel_in[0];
	wire logic wr_c0   = wr_req & wr_hit(wb_adr_in, STIMER_CTRL0_OFF);
	wire logic wr_c1   = wr_req & wr_hit(wb_adr_in, STIMER_CTRL1_OFF);
	wire logic wr_al   = wr_req & wr_hit(wb_adr_in, STIMER_CMPAL_OFF);
	wire logic wr_ah   = wr_req & wr_hit(wb_adr_in, STIMER_CMPAH_OFF);
	wire logic wr_p    = wr_req & wr_hit(wb_adr_in, STIMER_CMPP_OFF);
	wire logic wr_flag = wr_req & wr_hit(wb_adr_in, STIMER_FLAG_OFF);

	// ====================================================================
	// flag next values
	// compare mode with clear on a never reports p
	wire logic set_a    = match_a & (is_cmp | is_pwm);
	wire logic set_p    = (match_p | overflow) & (is_pwm | (is_cmp & ~clear_source_select));
	wire logic clr_a    = wr_flag & wb_dat_in[STIMER_FA_BIT];
	wire logic clr_p    = wr_flag & wb_dat_in[STIMER_FP_BIT];
	wire logic flag_a_d = set_a | (flag_a_q & ~clr_a);
	wire logic flag_p_d = set_p | (flag_p_q & ~clr_p);

	// ====================================================================
	// read path
	// the low control bits below the on bit have no storage and read as zero
	logic [7:0] rd_byte;
	always_comb begin
		case (wb_adr_in)
			STIMER_CTRL0_OFF: rd_byte = {4'h0, ctrl0_q[3:0]} & 8'h08 | {ctrl0_q[7:4], 4'h0};
			STIMER_CTRL1_OFF: rd_byte = ctrl1_q;
			STIMER_CNTL_OFF:  rd_byte = cnt_q[7:0];
			STIMER_CNTH_OFF:  rd_byte = cnt_q[15:8];
			STIMER_CMPAL_OFF: rd_byte = cmp_a_q[7:0];
			STIMER_CMPAH_OFF: rd_byte = cmp_a_q[15:8];
			STIMER_CMPP_OFF:  rd_byte = cmp_p_q;
			STIMER_FLAG_OFF:  rd_byte = {6'h00, flag_p_q, flag_a_q};
			default:          rd_byte = STIMER_BYTE_RST;
		endcase
	end

	// ====================================================================
	// control registers
	// mode bits should only change with the counter stopped; nothing here enforces it
	always_ff @(posedge clk_sys_in or negedge rst_n_q) begin
		if (!rst_n_q) begin
			ctrl0_q <= STIMER_BYTE_RST;
		end else if (wr_c0) begin
			ctrl0_q <= wb_dat_in[7:0] & 8'hF8;
		end
	end

	// control byte one holds mode, pin function, level, invert, swap and clear select
	always_ff @(posedge clk_sys_in or negedge rst_n_q) begin
		if (!rst_n_q) begin
			ctrl1_q <= STIMER_BYTE_RST;
		end else if (wr_c1) begin
			ctrl1_q <= wb_dat_in[7:0];
		end
	end

	// ====================================================================
	// compare values
	// no byte latching: a two-byte update briefly mixes old and new halves
	always_ff @(posedge clk_sys_in or negedge rst_n_q) begin
		if (!rst_n_q) begin
			cmp_a_q <= STIMER_WORD_RST;
		end else begin
			if (wr_al) begin
				cmp_a_q[7:0] <= wb_dat_in[7:0];
			end
			if (wr_ah) begin
				cmp_a_q[15:8] <= wb_dat_in[7:0];
			end
		end
	end

	// a zero here selects overflow as the p event
	always_ff @(posedge clk_sys_in or negedge rst_n_q) begin
		if (!rst_n_q) begin
			cmp_p_q <= STIMER_BYTE_RST;
		end else if (wr_p) begin
			cmp_p_q <= wb_dat_in[7:0];
		end
	end

	// ====================================================================
	// counter and start detect
	// the counter moves on every edge while on; stopping keeps its value
	always_ff @(posedge clk_sys_in or negedge rst_n_q) begin
		if (!rst_n_q) begin
			cnt_q <= STIMER_WORD_RST;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	// resets low like the on bit itself, so no false start follows reset
	always_ff @(posedge clk_sys_in or negedge rst_n_q) begin
		if (!rst_n_q) begin
			on_prev_q <= 1'b0;
		end else begin
			on_prev_q <= counter_on;
		end
	end

	// ====================================================================
	// match flags
	// write one to clear; a match in the same cycle wins so no event is lost
	always_ff @(posedge clk_sys_in or negedge rst_n_q) begin
		if (!rst_n_q) begin
			flag_a_q <= 1'b0;
		end else begin
			flag_a_q <= flag_a_d;
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_q) begin
		if (!rst_n_q) begin
			flag_p_q <= 1'b0;
		end else begin
			flag_p_q <= flag_p_d;
		end
	end

	// ====================================================================
	// bus response
	// read data is registered, so it stands only in the ack cycle
	always_ff @(posedge clk_sys_in or negedge rst_n_q) begin
		if (!rst_n_q) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= req;
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_q) begin
		if (!rst_n_q) begin
			rdata_q <= 32'h0000_0000;
		end else begin
			rdata_q <= {24'h00_0000, rd_byte};
		end
	end

	// ====================================================================
	// output pin registers
	// pin_q keeps the level before invert, so a toggle acts on the true state
	always_ff @(posedge clk_sys_in or negedge rst_n_q) begin
		if (!rst_n_q) begin
			pin_q <= 1'b0;
		end else begin
			pin_q <= pin_d;
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_q) begin
		if (!rst_n_q) begin
			pin_out_q <= 1'b0;
		end else begin
			pin_out_q <= pin_out_d;
		end
	end

	// released in timer/counter and capture modes so the pin can serve other uses
	always_ff @(posedge clk_sys_in or negedge rst_n_q) begin
		if (!rst_n_q) begin
			oe_n_q <= 1'b1;
		end else begin
			oe_n_q <= oe_n_d;
		end
	end

	// ====================================================================
	// ports
	// every port comes straight from a flop
	always_comb begin
		timer_pin_out      = pin_out_q;
		timer_pin_oe_n_out = oe_n_q;
		wb_ack_out         = ack_q;
		wb_dat_out         = rdata_q;
	end

endmodule

`default_nettype wire

// File: verif/stimer_assertions.sv
// Purpose: port checks for the timer block
// Assumes: control bytes shadowed from bus writes
// Notes:   flags and counter are judged by the bench
`timescale 1ns/1ps
`default_nettype none
module stimer_assertions
	import stimer_pkg::*;
(
	// clock, reset and bus
	input wire logic        clk_sys_in,
	input wire logic        nrst_in,
	input wire logic        wb_cyc_in,
	input wire logic        wb_stb_in,
	input wire logic        wb_we_in,
	input wire logic [4:0]  wb_adr_in,
	input wire logic [3:0]  wb_sel_in,
	input wire logic [31:0] wb_dat_in,
	input wire logic [31:0] wb_dat_out,
	input wire logic        wb_ack_out,
	// pin
	input wire logic        timer_pin_out,
	input wire logic        timer_pin_oe_n_out
);
	// ====
	// shadow taken on the same edge as the design, so no lag to allow for
	logic       on_q;
	logic [7:0] c1_q;
	wire logic  wr_take = wb_cyc_in && wb_stb_in && !wb_ack_out && wb_we_in && wb_sel_in[0];
	wire logic  is_cmp  = c1_q[7:6] == STIMER_MODE_CMP;
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			on_q <= 1'b0;
			c1_q <= 8'h00;
		end else if (wr_take && wb_adr_in == STIMER_CTRL0_OFF) begin
			on_q <= wb_dat_in[STIMER_ON_BIT];
		end else if (wr_take && wb_adr_in == STIMER_CTRL1_OFF) begin
			c1_q <= wb_dat_in[7:0];
		end
	end
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!nrst_in);
	// ====
	// properties
	chk_ack_pulse: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out ##1 !wb_ack_out)
		else $error("ack not one cycle");
	chk_ack_cause: assert property ($rose(wb_ack_out) |-> $past(wb_stb_in))
		else $error("ack without request");
	chk_read_width: assert property (wb_ack_out && !wb_we_in |-> wb_dat_out[31:8] == 24'h00_0000)
		else $error("read upper bits set");
	chk_timer_undriven: assert property (c1_q[7:6] == STIMER_MODE_TMR && on_q |-> timer_pin_oe_n_out)
		else $error("pin driven in timer mode");
	chk_cmp_driven: assert property (is_cmp && on_q |-> !timer_pin_oe_n_out)
		else $error("pin not driven");
	chk_start_level: assert property ($rose(on_q) && is_cmp |-> ##[1:2] timer_pin_out == (c1_q[3] ^ c1_q[2]))
		else $error("start level wrong");
	chk_none_still: assert property (is_cmp && c1_q[5:4] == 2'h0 && on_q && $past(on_q, 3)
		|=> $stable(timer_pin_out))
		else $error("pin moved with no function");
	chk_pwm_idle: assert property (c1_q[7:4] == 4'h8 && on_q && $past(on_q, 3)
		|-> timer_pin_out == (!c1_q[3] ^ c1_q[2]))
		else $error("pwm idle level wrong");
endmodule
bind stimer_top stimer_assertions u_chk (.clk_sys_in, .nrst_in, .wb_cyc_in, .wb_stb_in, .wb_we_in,
	.wb_adr_in, .wb_sel_in, .wb_dat_in, .wb_dat_out, .wb_ack_out, .timer_pin_out, .timer_pin_oe_n_out);
`default_nettype wire

// File: verif/testbench.sv
// Purpose: self-checking bench for the timer block
// Assumes: registers reached over classic wishbone
// Notes:   pwm duty judged by high cycles over whole periods
`timescale 1ns/1ps
`default_nettype none
module testbench
	import stimer_pkg::*;
;
	// ====
	// design ports
	logic        clk_sys_in = 1'b0;
	logic        nrst_in = 1'b0;
	logic        wb_cyc_in = 1'b0;
	logic        wb_stb_in = 1'b0;
	logic        wb_we_in = 1'b0;
	logic [4:0]  wb_adr_in = 5'h00;
	logic [3:0]  wb_sel_in = 4'h0;
	logic [31:0] wb_dat_in = 32'h0000_0000;
	logic [31:0] wb_dat_out;
	logic        wb_ack_out;
	logic        timer_pin_out;
	logic        timer_pin_oe_n_out;
	int          miscompares = 0;
	int          total_checks = 0;
	always #10 clk_sys_in = ~clk_sys_in;
	stimer_top uut (.clk_sys_in, .nrst_in, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_sel_in,
		.wb_dat_in, .wb_dat_out, .wb_ack_out, .timer_pin_out, .timer_pin_oe_n_out);
	// ====
	// shared tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic bus(input logic [4:0] a, input logic w, input logic [7:0] d, output logic [31:0] q);
		int n;
		@(posedge clk_sys_in);
		wb_cyc_in <= 1'b1;
		wb_stb_in <= 1'b1;
		wb_we_in <= w;
		wb_adr_in <= a;
		wb_sel_in <= 4'hF;
		wb_dat_in <= {24'h00_0000, d};
		for (n = 0; n < 20 && wb_ack_out !== 1'b1; n++) begin
			@(posedge clk_sys_in);
		end
		if (wb_ack_out !== 1'b1) begin
			miscompares++;
			end_of_test();
		end
		q = wb_dat_out;
		wb_cyc_in <= 1'b0;
		wb_stb_in <= 1'b0;
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		logic [31:0] q;
		bus(a, 1'b1, d, q);
	endtask
	task automatic rdc(input logic [4:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(a, 1'b0, 8'h00, q);
		chk(q, e);
	endtask
	// restart with new control byte; skipping 16 cycles lets the pin settle
	task automatic run(input logic [7:0] c1, input int n, output int hi);
		wr(STIMER_CTRL0_OFF, 8'h00);
		wr(STIMER_FLAG_OFF, 8'h03);
		wr(STIMER_CTRL1_OFF, c1);
		wr(STIMER_CTRL0_OFF, 8'h08);
		repeat (16) @(posedge clk_sys_in);
		hi = 0;
		repeat (n) begin
			@(posedge clk_sys_in);
			hi += (timer_pin_out === 1'b1);
		end
	endtask
	// ====
	// scenarios
	task automatic t_regs();
		logic [4:0] offs [5] = '{STIMER_CNTL_OFF, STIMER_CNTH_OFF, STIMER_CMPAL_OFF, STIMER_CMPAH_OFF,
			STIMER_CMPP_OFF};
		foreach (offs[i]) begin
			rdc(offs[i], 32'h0000_0000);
		end
		wr(STIMER_CMPAL_OFF, 8'hA5);
		wr(STIMER_CMPAH_OFF, 8'h5A);
		wr(STIMER_CNTL_OFF, 8'h77);
		rdc(STIMER_CMPAL_OFF, 32'h0000_00A5);
		rdc(STIMER_CMPAH_OFF, 32'h0000_005A);
		rdc(STIMER_CNTL_OFF, 32'h0000_0000);
	endtask
	task automatic t_cmp_a();
		int          hi;
		logic [31:0] q;
		wr(STIMER_CMPAL_OFF, 8'h10);
		wr(STIMER_CMPAH_OFF, 8'h00);
		wr(STIMER_CMPP_OFF, 8'h00);
		run(8'h39, 170, hi);
		chk(32'(hi > 40 && hi < 130), 32'h1);
		rdc(STIMER_FLAG_OFF, 32'h0000_0001);
		wr(STIMER_CTRL0_OFF, 8'h00);
		bus(STIMER_CNTL_OFF, 1'b0, 8'h00, q);
		chk(32'(q <= 32'h10), 32'h1);
		repeat (5) @(posedge clk_sys_in);
		rdc(STIMER_CNTL_OFF, q);
	endtask
	task automatic t_cmp_p();
		int hi;
		wr(STIMER_CMPP_OFF, 8'h01);
		wr(STIMER_CMPAL_OFF, 8'h40);
		for (int f = 0; f < 3; f++) begin
			run({2'h0, f[1:0], f != 2, 3'h0}, 600, hi);
			chk(32'(timer_pin_out), 32'(f != 1));
			rdc(STIMER_FLAG_OFF, 32'h0000_0003);
			rdc(STIMER_CNTH_OFF, 32'h0000_0000);
		end
		wr(STIMER_CMPAL_OFF, 8'h10);
		run(8'hC1, 100, hi);
		chk(32'(timer_pin_oe_n_out), 32'h1);
		rdc(STIMER_FLAG_OFF, 32'h0000_0001);
	endtask
	task automatic t_pwm();
		int hi;
		wr(STIMER_CMPAL_OFF, 8'h80);
		run(8'hA8, 512, hi);
		chk(hi, 256);
		rdc(STIMER_FLAG_OFF, 32'h0000_0003);
		run(8'hAA, 1024, hi);
		chk(hi, 1024);
		run(8'h88, 512, hi);
		chk(hi, 0);
		wr(STIMER_CMPAL_OFF, 8'h00);
		wr(STIMER_CMPAH_OFF, 8'h01);
		run(8'hA8, 512, hi);
		chk(hi, 512);
		run(8'hAC, 512, hi);
		chk(hi, 0);
	endtask
	initial begin
		repeat (6) @(posedge clk_sys_in);
		nrst_in <= 1'b1;
		repeat (3) @(posedge clk_sys_in);
		t_regs();
		t_cmp_a();
		t_cmp_p();
		t_pwm();
		end_of_test();
	end
endmodule
`default_nettype wire
